// File: tb_top.sv
// Self-checking bench for the trap status and pending vector block.
// Assumes the source model file and the design package are compiled first.
`timescale 1ns/1ps
module tb_top;
  logic                       mclk_in;
  logic                       resetn_in;
  logic                       clk_en;
  logic                       fire;
  logic                       upper_bit;
  logic                       irq_valid;
  logic                       glob_en;
  logic                       loop_ovf;
  logic                       aux_loss;
  logic                       sw_hard;
  logic [3:0]                 sel;
  logic [7:0]                 user_req;
  logic [7:0]                 vec;
  logic [23:0]                user_prio;
  logic [15:0]                rdata;
  logic [15:0]                rd_val;
  trap_irq_pkg::reg_req_t     req;
  trap_irq_pkg::trap_events_t traps;
  integer                     errors;
  integer                     checks;
  integer                     seed;
  integer                     i;
  integer                     k;
  integer                     p;

  trap_interrupt_status_control dut (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .clk_en_in(clk_en),
    .req_in(req), .rdata_out(rdata), .traps_in(traps),
    .loop_ovf_in(loop_ovf), .aux_pll_loss_in(aux_loss),
    .sw_hard_trap_in(sw_hard), .user_req_in(user_req),
    .user_prio_in(user_prio), .priority_upper_bit_in(upper_bit),
    .global_irq_enable_out(glob_en), .irq_valid_out(irq_valid),
    .irq_vector_out(vec));

  trap_source_model src (
    .mclk_in(mclk_in), .fire_in(fire), .sel_in(sel), .traps_out(traps),
    .loop_ovf_out(loop_ovf), .aux_pll_loss_out(aux_loss),
    .sw_hard_trap_out(sw_hard));

  // ****************************************
  // Expectation functions
  // ****************************************
  // Writable bits of each register after writing all ones
  function automatic logic [15:0] exp_mask(input integer a);
    case (a)
      0: exp_mask = 16'h000e;
      1: exp_mask = 16'h8000;
      2: exp_mask = 16'h0011;
      3: exp_mask = 16'h0001;
      default: exp_mask = 16'h0000;
    endcase
  endfunction

  // Source index to vector code; only traps with a code are asked
  function automatic logic [7:0] exp_vec(input integer s);
    exp_vec = (s < 4) ? s[7:0] : (s == 4) ? 8'h04 : 8'h06;
  endfunction

  // Flag register and its expected value once the source fired
  function automatic logic [2:0] flag_addr(input integer s);
    flag_addr = (s < 6) ? 3'h0 : (s == 8) ? 3'h3 : 3'h2;
  endfunction
  function automatic logic [15:0] exp_flag(input integer s);
    case (s)
      0: exp_flag = 16'h0002;
      1: exp_flag = 16'h0008;
      3: exp_flag = 16'h0004;
      6: exp_flag = 16'h0010;
      7, 8: exp_flag = 16'h0001;
      default: exp_flag = 16'h0000;
    endcase
  endfunction

  // ****************************************
  // Bench tasks
  // ****************************************
  task automatic check(input string name, input logic [15:0] got,
                       input logic [15:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_in);
    req <= '0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [2:0] a);
    @(posedge mclk_in);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_in);
    req <= '0;
    #1 rd_val = rdata;
  endtask

  task automatic fire_src(input integer s);
    @(posedge mclk_in);
    fire <= 1'b1;
    sel <= s[3:0];
    @(posedge mclk_in);
    fire <= 1'b0;
    @(posedge mclk_in);
    #1;
  endtask

  task automatic test_done;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ****************************************
  // Clock, watchdog and reserved-code monitor
  // ****************************************
  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end

  // A hang costs a mismatch and ends the run
  initial begin
    repeat (20000) @(posedge mclk_in);
    errors = errors + 1;
    test_done;
  end

  // Sampled away from the launching edge so the vector has settled
  always @(negedge mclk_in) begin
    if (resetn_in === 1'b1)
      check("vec_reserved", {15'h0, vec === 8'h05 || vec === 8'h07 ||
            vec === 8'hff}, 16'h0000);
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    errors = 0; checks = 0; seed = 34757;
    resetn_in = 1'b0; fire = 1'b0; sel = 4'h0; upper_bit = 1'b0;
    user_req = 8'h00; user_prio = 24'h000000; req = '0;
    clk_en = 1'b1;
    repeat (20) @(posedge mclk_in);
    resetn_in <= 1'b1;
    // Reset values, including unmapped places
    for (k = 0; k < 8; k++) begin
      reg_rd(k[2:0]);
      check("reset_val", rd_val, (k == 1) ? 16'h8000 : 16'h0000);
    end
    check("glob_en_reset", {15'h0, glob_en}, 16'h0001);
    $display("test reset done");
    // Unimplemented bits and read-only places ignore writes
    for (k = 0; k < 4; k++) begin
      reg_wr(k[2:0], 16'hffff);
      reg_rd(k[2:0]);
      check("write_mask", rd_val, exp_mask(k));
      reg_wr(k[2:0], (k == 1) ? 16'h8000 : 16'h0000);
    end
    for (k = 4; k < 8; k++) begin
      reg_wr(k[2:0], 16'($random(seed)));
      reg_rd(k[2:0]);
      check("ro_unmapped", rd_val, 16'h0000);
    end
    $display("test masks done");
    // Every trap source: flag sticks where one exists; vector and level latched for sources 0 to 5
    for (k = 0; k < 9; k++) begin
      fire_src(k);
      if (k < 6) begin
        check("trap_vec", {8'h00, vec}, {8'h00, exp_vec(k)});
        reg_rd(trap_irq_pkg::ADDR_PENDING);
        check("trap_pend", rd_val, {8'h0f, exp_vec(k)});
      end
      repeat (3) @(posedge mclk_in);
      reg_rd(flag_addr(k));
      check("flag_set", rd_val, exp_flag(k));
      reg_wr(flag_addr(k), 16'h0000);
      reg_rd(flag_addr(k));
      check("flag_clr", rd_val, 16'h0000);
    end
    $display("test traps done");
    // Random user sources and priorities
    for (k = 0; k < 16; k++) begin
      i = $random(seed) & 7;
      p = 1 + (($random(seed) & 32'h7fffffff) % 7);
      @(posedge mclk_in);
      user_req <= 8'h01 << i;
      user_prio <= 24'(p) << (3 * i);
      @(posedge mclk_in);
      #1 check("user_valid", {15'h0, irq_valid}, 16'h0001);
      check("user_vec", {8'h00, vec}, 16'(8 + i));
      reg_rd(trap_irq_pkg::ADDR_PENDING);
      check("user_pend", rd_val, {4'h0, 4'(p), 8'(8 + i)});
      @(posedge mclk_in);
      user_req <= 8'h00;
    end
    // Lowest two user codes: tie then higher priority
    @(posedge mclk_in);
    user_req <= 8'h03;
    user_prio <= 24'h00001b;
    @(posedge mclk_in);
    #1 check("user_tie", {8'h00, vec}, 16'h0008);
    user_prio <= 24'h00002b;
    @(posedge mclk_in);
    #1 check("user_nine", {8'h00, vec}, 16'h0009);
    $display("test user done");
    // Gating by the upper priority bit and the global enable
    upper_bit <= 1'b1;
    @(posedge mclk_in);
    #1 check("upper_block", {15'h0, irq_valid}, 16'h0000);
    upper_bit <= 1'b0;
    reg_wr(trap_irq_pkg::ADDR_GLOBAL, 16'h0000);
    @(posedge mclk_in);
    #1 check("glob_off", {15'h0, glob_en}, 16'h0000);
    check("glob_block", {15'h0, irq_valid}, 16'h0000);
    fire_src(3);
    check("trap_unmasked", {8'h00, vec}, 16'h0003);
    reg_wr(trap_irq_pkg::ADDR_TRAP_A, 16'h0000);
    reg_wr(trap_irq_pkg::ADDR_GLOBAL, 16'h8000);
    @(posedge mclk_in);
    #1 check("glob_on", {15'h0, irq_valid}, 16'h0001);
    // Clock enable low: the write to the global enable is lost
    clk_en <= 1'b0;
    reg_wr(trap_irq_pkg::ADDR_GLOBAL, 16'h0000);
    clk_en <= 1'b1;
    @(posedge mclk_in);
    #1 check("clk_en_hold", {15'h0, glob_en}, 16'h0001);
    // Mid-run reset with a flag set and a vector latched
    fire_src(1);
    user_req <= 8'h00;
    resetn_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    resetn_in <= 1'b1;
    reg_rd(trap_irq_pkg::ADDR_TRAP_A);
    check("rst_flag", rd_val, 16'h0000);
    check("rst_vec", {8'h00, vec}, 16'h0000);
    check("rst_glob", {15'h0, glob_en}, 16'h0001);
    $display("test gating done");
    test_done;
  end
endmodule

// File: trap_interrupt_status_control.sv
// Trap status flags, global interrupt enable and pending register.
// Assumes trap and interrupt sources are synchronous to mclk_in.
//
// Summary of operation
// - Address error trap sets address fault flag
// - Stack error trap sets stack fault flag
// - Oscillator failure trap sets clock loss flag
// - Global enable resets set; gates interrupts only
// - Loop-stack overflow sets its soft trap flag
// - Aux PLL lock loss sets its flag
// - Software hard trap sets its flag
// - Pending register shows four-bit new level
// - Pending register low byte holds vector
// - Math error vector 4, soft error 6
// - Codes 5, 7, 255 never assigned
// - User vectors start at 8, then 9
// - Vector and level latched into pending register
// - Upper priority bit set blocks user interrupts
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module trap_interrupt_status_control (
  input  wire logic                                 mclk_in,
  input  wire logic                                 resetn_in,
  input  wire logic                                 clk_en_in,
  input  wire trap_irq_pkg::reg_req_t               req_in,
  output logic [15:0]                               rdata_out,
  input  wire trap_irq_pkg::trap_events_t           traps_in,
  input  wire logic                                 loop_ovf_in,
  input  wire logic                                 aux_pll_loss_in,
  input  wire logic                                 sw_hard_trap_in,
  input  wire logic [trap_irq_pkg::NUM_USER-1:0]    user_req_in,
  input  wire logic [3*trap_irq_pkg::NUM_USER-1:0]  user_prio_in,
  input  wire logic                                 priority_upper_bit_in,
  output logic                                      global_irq_enable_out,
  output logic                                      irq_valid_out,
  output logic [7:0]                                irq_vector_out
);

  // ****************************************************************
  // Flag and control state
  // ****************************************************************
  logic address_fault_flag_q, address_fault_flag_d;
  logic stack_fault_flag_q,   stack_fault_flag_d;
  logic clock_loss_flag_q,    clock_loss_flag_d;
  logic loop_stack_overflow_flag_q, loop_stack_overflow_flag_d;
  logic aux_pll_lock_loss_flag_q,   aux_pll_lock_loss_flag_d;
  logic sw_hard_trap_flag_q,  sw_hard_trap_flag_d;
  logic global_irq_enable_q,  global_irq_enable_d;
  logic [3:0] pending_priority_level_q, pending_priority_level_d;
  logic [7:0] pending_vector_code_q,    pending_vector_code_d;
  logic [15:0] rdata_q, rdata_d;

  logic       sel_valid;
  logic [7:0] sel_vector;
  logic [3:0] sel_level;
  logic       irq_allowed;
  logic       wr_a, wr_g, wr_s, wr_h;

  assign wr_a = req_in.wr && req_in.addr == trap_irq_pkg::ADDR_TRAP_A;
  assign wr_g = req_in.wr && req_in.addr == trap_irq_pkg::ADDR_GLOBAL;
  assign wr_s = req_in.wr && req_in.addr == trap_irq_pkg::ADDR_SOFT_TRAP;
  assign wr_h = req_in.wr && req_in.addr == trap_irq_pkg::ADDR_SW_HARD;

  // upper priority bit blocks user interrupts
  assign irq_allowed = global_irq_enable_q && !priority_upper_bit_in;

  // Picker for the pending source; traps ignore the gate
  vector_select u_select (
    .traps_in       (traps_in),
    .user_req_in    (user_req_in),
    .user_prio_in   (user_prio_in),
    .irq_allowed_in (irq_allowed),
    .valid_out      (sel_valid),
    .vector_out     (sel_vector),
    .level_out      (sel_level)
  );

  // Next flag values: a write stores the bit, an event sets it.
  // The set term is ORed last so a same-cycle event beats the clear.
  always_comb begin
    address_fault_flag_d       = address_fault_flag_q;
    stack_fault_flag_d         = stack_fault_flag_q;
    clock_loss_flag_d          = clock_loss_flag_q;
    loop_stack_overflow_flag_d = loop_stack_overflow_flag_q;
    aux_pll_lock_loss_flag_d   = aux_pll_lock_loss_flag_q;
    sw_hard_trap_flag_d        = sw_hard_trap_flag_q;
    global_irq_enable_d        = global_irq_enable_q;
    if (wr_a) begin
      address_fault_flag_d =
        req_in.wdata[trap_irq_pkg::BIT_ADDRESS_FAULT];
      stack_fault_flag_d = req_in.wdata[trap_irq_pkg::BIT_STACK_FAULT];
      clock_loss_flag_d  = req_in.wdata[trap_irq_pkg::BIT_CLOCK_LOSS];
    end
    if (wr_g) begin
      global_irq_enable_d = req_in.wdata[trap_irq_pkg::BIT_GLOBAL_EN];
    end
    if (wr_s) begin
      loop_stack_overflow_flag_d =
        req_in.wdata[trap_irq_pkg::BIT_LOOP_OVF];
      aux_pll_lock_loss_flag_d = req_in.wdata[trap_irq_pkg::BIT_AUX_PLL];
    end
    if (wr_h) begin
      sw_hard_trap_flag_d = req_in.wdata[trap_irq_pkg::BIT_SW_HARD];
    end
    address_fault_flag_d = address_fault_flag_d | traps_in.address_fault;
    stack_fault_flag_d = stack_fault_flag_d | traps_in.stack_fault;
    clock_loss_flag_d = clock_loss_flag_d | traps_in.clock_loss;
    loop_stack_overflow_flag_d = loop_stack_overflow_flag_d | loop_ovf_in;
    aux_pll_lock_loss_flag_d = aux_pll_lock_loss_flag_d | aux_pll_loss_in;
    sw_hard_trap_flag_d = sw_hard_trap_flag_d | sw_hard_trap_in;
  end

  // latch vector and level of the pending source
  always_comb begin
    pending_vector_code_d    = pending_vector_code_q;
    pending_priority_level_d = pending_priority_level_q;
    if (sel_valid) begin
      pending_vector_code_d    = sel_vector;
      pending_priority_level_d = sel_level;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // unimplemented bits read zero; unmapped addresses read zero
  always_comb begin
    rdata_d = 16'h0000;
    if (req_in.rd) begin
      case (req_in.addr)
        trap_irq_pkg::ADDR_TRAP_A: begin
          rdata_d[trap_irq_pkg::BIT_ADDRESS_FAULT] = address_fault_flag_q;
          rdata_d[trap_irq_pkg::BIT_STACK_FAULT]   = stack_fault_flag_q;
          rdata_d[trap_irq_pkg::BIT_CLOCK_LOSS]    = clock_loss_flag_q;
        end
        trap_irq_pkg::ADDR_GLOBAL: begin
          rdata_d[trap_irq_pkg::BIT_GLOBAL_EN] = global_irq_enable_q;
        end
        trap_irq_pkg::ADDR_SOFT_TRAP: begin
          rdata_d[trap_irq_pkg::BIT_LOOP_OVF] = loop_stack_overflow_flag_q;
          rdata_d[trap_irq_pkg::BIT_AUX_PLL]  = aux_pll_lock_loss_flag_q;
        end
        trap_irq_pkg::ADDR_SW_HARD: begin
          rdata_d[trap_irq_pkg::BIT_SW_HARD] = sw_hard_trap_flag_q;
        end
        // level field; vector in low byte
        trap_irq_pkg::ADDR_PENDING: begin
          rdata_d[trap_irq_pkg::LVL_LSB +: 4] = pending_priority_level_q;
          rdata_d[7:0] = pending_vector_code_q;
        end
        default: begin
          rdata_d = 16'h0000;
        end
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // All state holds while the clock enable is low
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      address_fault_flag_q       <= 1'b0;
      stack_fault_flag_q         <= 1'b0;
      clock_loss_flag_q          <= 1'b0;
      loop_stack_overflow_flag_q <= 1'b0;
      aux_pll_lock_loss_flag_q   <= 1'b0;
      sw_hard_trap_flag_q        <= 1'b0;
      global_irq_enable_q        <= trap_irq_pkg::GLOBAL_EN_RESET;
      pending_vector_code_q      <= 8'h00;
      pending_priority_level_q   <= 4'h0;
      rdata_q                    <= 16'h0000;
    end else if (clk_en_in) begin
      address_fault_flag_q       <= address_fault_flag_d;
      stack_fault_flag_q         <= stack_fault_flag_d;
      clock_loss_flag_q          <= clock_loss_flag_d;
      loop_stack_overflow_flag_q <= loop_stack_overflow_flag_d;
      aux_pll_lock_loss_flag_q   <= aux_pll_lock_loss_flag_d;
      sw_hard_trap_flag_q        <= sw_hard_trap_flag_d;
      global_irq_enable_q        <= global_irq_enable_d;
      pending_vector_code_q      <= pending_vector_code_d;
      pending_priority_level_q   <= pending_priority_level_d;
      rdata_q                    <= rdata_d;
    end
  end

  assign rdata_out             = rdata_q;
  assign global_irq_enable_out = global_irq_enable_q;
  assign irq_valid_out         = sel_valid;
  assign irq_vector_out        = pending_vector_code_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_addr_fault_set: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    (clk_en_in && traps_in.address_fault) |=> address_fault_flag_q)
    else $error("address fault flag not set");

  chk_stack_fault_set: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    (clk_en_in && traps_in.stack_fault) |=> stack_fault_flag_q)
    else $error("stack fault flag not set");

  chk_clock_loss_set: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    (clk_en_in && traps_in.clock_loss) |=>
      (clock_loss_flag_q && pending_vector_code_q == 8'h00))
    else $error("clock loss flag or vector wrong");

  chk_gie_blocks_irq: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    (!global_irq_enable_q && sel_valid) |-> sel_vector < 8'h08)
    else $error("user interrupt passed with enable clear");

  chk_loop_ovf_set: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    (clk_en_in && loop_ovf_in) |=> loop_stack_overflow_flag_q)
    else $error("loop overflow flag not set");

  chk_aux_pll_set: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    (clk_en_in && aux_pll_loss_in) |=> aux_pll_lock_loss_flag_q)
    else $error("aux pll flag not set");

  chk_sw_hard_set: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    (clk_en_in && sw_hard_trap_in) |=> sw_hard_trap_flag_q)
    else $error("software hard trap flag not set");

  chk_pending_read: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    (clk_en_in && req_in.rd && req_in.addr == trap_irq_pkg::ADDR_PENDING)
    |=> (rdata_out == {4'h0, $past(pending_priority_level_q),
                       $past(pending_vector_code_q)}))
    else $error("pending register read mismatch");

  chk_no_reserved: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    sel_valid |-> !(sel_vector inside {8'h05, 8'h07, 8'hff}))
    else $error("reserved vector code selected");

  chk_upper_blocks: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    (priority_upper_bit_in && sel_valid) |-> sel_level == 4'hf)
    else $error("user interrupt passed at high level");

  chk_flag_sticky: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    (address_fault_flag_q && !wr_a) |=> address_fault_flag_q)
    else $error("trap flag cleared without a write");

  chk_pending_latch: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    (clk_en_in && sel_valid) |=>
      (pending_vector_code_q == $past(sel_vector) &&
       pending_priority_level_q == $past(sel_level)))
    else $error("pending vector or level not latched");

  // Holding matters: software may read long after the source went away
  chk_pending_hold: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    (clk_en_in && !sel_valid) |=> $stable(pending_vector_code_q))
    else $error("pending vector changed with nothing pending");

  chk_user_vec_base: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    (sel_valid && sel_level != trap_irq_pkg::TRAP_LEVEL) |->
      sel_vector >= trap_irq_pkg::VEC_USER_BASE)
    else $error("user interrupt below the user vector base");

  chk_hard_code: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    (traps_in.hard_trap && !traps_in.clock_loss &&
     !traps_in.address_fault) |->
      sel_vector == trap_irq_pkg::VEC_HARD_TRAP)
    else $error("hard trap vector wrong");

  chk_math_code: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    (traps_in.math_error && !traps_in.clock_loss && !traps_in.hard_trap &&
     !traps_in.address_fault && !traps_in.stack_fault) |->
      sel_vector == trap_irq_pkg::VEC_MATH_ERROR)
    else $error("math error vector wrong");

  chk_trap_a_unused: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    (clk_en_in && req_in.rd && req_in.addr == trap_irq_pkg::ADDR_TRAP_A)
    |=> (rdata_out & 16'hfff1) == 16'h0000)
    else $error("unimplemented trap bits read nonzero");

  chk_soft_unused: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    (clk_en_in && req_in.rd && req_in.addr == trap_irq_pkg::ADDR_SOFT_TRAP)
    |=> (rdata_out & 16'hffee) == 16'h0000)
    else $error("unimplemented soft trap bits read nonzero");

  chk_gie_write: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    (clk_en_in && wr_g) |=>
      global_irq_enable_q == $past(req_in.wdata[trap_irq_pkg::BIT_GLOBAL_EN]))
    else $error("global enable write did not land");

  // A frozen block must not lose software state or read data
  chk_clk_en_hold: assert property (
    @(posedge mclk_in) disable iff (!resetn_in)
    !clk_en_in |=> ($stable(global_irq_enable_q) && $stable(rdata_out)))
    else $error("state changed with clock enable low");

endmodule

// File: trap_irq_pkg.sv
// Package for the trap and interrupt status/control block.
// Assumes a 16-bit register port with word indices as addresses.
package trap_irq_pkg;

  // Register indices (word addresses on the plain port)
  localparam logic [2:0] ADDR_TRAP_A    = 3'h0;
  localparam logic [2:0] ADDR_GLOBAL    = 3'h1;
  localparam logic [2:0] ADDR_SOFT_TRAP = 3'h2;
  localparam logic [2:0] ADDR_SW_HARD   = 3'h3;
  localparam logic [2:0] ADDR_PENDING   = 3'h4;

  // Field positions
  localparam int BIT_ADDRESS_FAULT = 3;
  localparam int BIT_STACK_FAULT   = 2;
  localparam int BIT_CLOCK_LOSS    = 1;
  localparam int BIT_GLOBAL_EN     = 15;
  localparam int BIT_LOOP_OVF      = 4;
  localparam int BIT_AUX_PLL       = 0;
  localparam int BIT_SW_HARD       = 0;
  localparam int LVL_LSB           = 8;

  // Reset values
  localparam logic GLOBAL_EN_RESET = 1'b1;

  // Trap and interrupt vector codes
  localparam logic [7:0] VEC_CLOCK_LOSS    = 8'h00;
  localparam logic [7:0] VEC_ADDRESS_FAULT = 8'h01;
  localparam logic [7:0] VEC_HARD_TRAP     = 8'h02;
  localparam logic [7:0] VEC_STACK_FAULT   = 8'h03;
  localparam logic [7:0] VEC_MATH_ERROR    = 8'h04;
  localparam logic [7:0] VEC_SOFT_ERROR    = 8'h06;
  localparam logic [7:0] VEC_USER_BASE     = 8'h08;
  localparam logic [7:0] VEC_RSVD_FIVE     = 8'h05;
  localparam logic [7:0] VEC_RSVD_SEVEN    = 8'h07;
  localparam logic [7:0] VEC_RSVD_TOP      = 8'hff;

  // Number of user interrupt sources handled
  localparam int NUM_USER = 8;

  // Trap level used for all trap vectors
  localparam logic [3:0] TRAP_LEVEL = 4'hf;

  // Trap event bundle
  typedef struct packed {
    logic clock_loss;
    logic address_fault;
    logic hard_trap;
    logic stack_fault;
    logic math_error;
    logic soft_error;
  } trap_events_t;

  // Register port request
  typedef struct packed {
    logic [2:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

endpackage

// File: trap_source_model.sv
// Behavioural model of the trap sources around the status block.
// Assumes the bench asks for one source at a time, on the core clock.
`timescale 1ns/1ps
module trap_source_model (
  input  wire logic                  mclk_in,
  input  wire logic                  fire_in,
  input  wire logic [3:0]            sel_in,
  output trap_irq_pkg::trap_events_t traps_out,
  output logic                       loop_ovf_out,
  output logic                       aux_pll_loss_out,
  output logic                       sw_hard_trap_out
);
  // ****************************************
  // Source pulses
  // ****************************************
  logic [8:0] pulse_q;
  logic [8:0] pulse_d;

  // only real sources exist
  // Nine sources only, so no reserved vector code can ever be requested
  always_comb begin
    pulse_d = fire_in ? (9'h001 << sel_in) : 9'h000;
  end

  // One-cycle pulse, registered so it never races the bench edge
  always_ff @(posedge mclk_in) begin
    pulse_q <= pulse_d;
  end

  // Index 0 is clock loss, index 5 is soft error
  assign traps_out        = {pulse_q[0], pulse_q[1], pulse_q[2],
                             pulse_q[3], pulse_q[4], pulse_q[5]};
  assign loop_ovf_out     = pulse_q[6];
  assign aux_pll_loss_out = pulse_q[7];
  assign sw_hard_trap_out = pulse_q[8];
endmodule

// File: vector_select.sv
// Priority picker: selects the pending trap or user interrupt.
// Assumes requests and priorities are synchronous to the core clock.
`timescale 1ns/1ps
module vector_select (
  input  wire trap_irq_pkg::trap_events_t       traps_in,
  input  wire logic [trap_irq_pkg::NUM_USER-1:0] user_req_in,
  input  wire logic [3*trap_irq_pkg::NUM_USER-1:0] user_prio_in,
  input  wire logic                              irq_allowed_in,
  output logic                                   valid_out,
  output logic [7:0]                             vector_out,
  output logic [3:0]                             level_out
);

  // Per-source qualified priority, zero when not eligible
  logic [2:0] prio_q [trap_irq_pkg::NUM_USER];

  genvar g;
  generate
    for (g = 0; g < trap_irq_pkg::NUM_USER; g++) begin : gen_src
      assign prio_q[g] = (user_req_in[g] && irq_allowed_in) ?
                         user_prio_in[3*g +: 3] : 3'h0;
    end
  endgenerate

  // Traps win over interrupts; lower vector code wins among traps
  always_comb begin
    logic [2:0] best;
    best       = 3'h0;
    valid_out  = 1'b0;
    vector_out = 8'h00;
    level_out  = 4'h0;
    if (traps_in.clock_loss) begin
      valid_out  = 1'b1;
      vector_out = trap_irq_pkg::VEC_CLOCK_LOSS;
      level_out  = trap_irq_pkg::TRAP_LEVEL;
    end else if (traps_in.address_fault) begin
      valid_out  = 1'b1;
      vector_out = trap_irq_pkg::VEC_ADDRESS_FAULT;
      level_out  = trap_irq_pkg::TRAP_LEVEL;
    end else if (traps_in.hard_trap) begin
      valid_out  = 1'b1;
      vector_out = trap_irq_pkg::VEC_HARD_TRAP;
      level_out  = trap_irq_pkg::TRAP_LEVEL;
    end else if (traps_in.stack_fault) begin
      valid_out  = 1'b1;
      vector_out = trap_irq_pkg::VEC_STACK_FAULT;
      level_out  = trap_irq_pkg::TRAP_LEVEL;
    end else if (traps_in.math_error) begin
      valid_out  = 1'b1;
      vector_out = trap_irq_pkg::VEC_MATH_ERROR;
      level_out  = trap_irq_pkg::TRAP_LEVEL;
    end else if (traps_in.soft_error) begin
      valid_out  = 1'b1;
      vector_out = trap_irq_pkg::VEC_SOFT_ERROR;
      level_out  = trap_irq_pkg::TRAP_LEVEL;
    end else begin
      // user vectors from code 8; lowest index wins on a tie
      for (int i = trap_irq_pkg::NUM_USER - 1; i >= 0; i--) begin
        if (prio_q[i] != 3'h0 && prio_q[i] >= best) begin
          best       = prio_q[i];
          valid_out  = 1'b1;
          vector_out = trap_irq_pkg::VEC_USER_BASE + 8'(i);
          level_out  = {1'b0, prio_q[i]};
        end
      end
    end
  end

endmodule
